//--- shared/lsad_regs.svh
// Register offsets, field positions and reset values of the segment attribute decoder.
`ifndef LSAD_REGS_SVH
`define LSAD_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define LSAD_IDX_ATTR_MAP_0   8'h59
`define LSAD_IDX_ATTR_MAP_1   8'h5A
`define LSAD_IDX_ATTR_MAP_2   8'h5B
`define LSAD_IDX_ATTR_MAP_3   8'h5C
`define LSAD_IDX_ATTR_MAP_4   8'h5D
`define LSAD_IDX_ATTR_MAP_5   8'h5E
`define LSAD_IDX_ATTR_MAP_6   8'h5F
`define LSAD_NUM_REGS         7
`define LSAD_NUM_SEGS         14
`define LSAD_ATTR_RESET       8'h00

// ----------------------------------------------------------------------------
// Field positions inside one 4-bit segment field
// ----------------------------------------------------------------------------
`define LSAD_FLD_READ         0
`define LSAD_FLD_WRITE        1
`define LSAD_FLD_CACHE        2
`define LSAD_FIELD_MASK       8'h77

// ----------------------------------------------------------------------------
// Address window of the legacy range
// ----------------------------------------------------------------------------
`define LSAD_VIDEO_BASE       20'hA0000
`define LSAD_EXP_BASE         20'hC0000
`define LSAD_BIOS_BASE        20'hF0000

`endif

//--- shared/lsad_pkg.sv
// Types shared by the segment attribute decoder modules.
package lsad_pkg;

	typedef enum logic [1:0] {
		LSAD_DEST_NONE,
		LSAD_DEST_DRAM,
		LSAD_DEST_PCI
	} lsad_dest_e;

	typedef struct packed {
		logic cache;
		logic write;
		logic read;
	} lsad_attr_s;

endpackage

//--- shared/lsad_seg_if.sv
// Carries the attribute looked up for one access between the decoder and its lookup.
interface lsad_seg_if;
	import lsad_pkg::*;
	logic [31:0] addr;
	logic        in_range;
	logic        fixed_pci;
	lsad_attr_s  attr;

	modport lookup (input addr, output in_range, output fixed_pci, output attr);
	modport user   (output addr, input in_range, input fixed_pci, input attr);
endinterface

//--- design/lsad_seg_lookup.sv
// Combinational lookup of segment attributes from an access address.
`include "lsad_regs.svh"

module lsad_seg_lookup (
	// Attribute registers
	input  wire logic [7:0] i_attr [`LSAD_NUM_REGS],
	// Lookup channel
	lsad_seg_if.lookup      seg
);
	import lsad_pkg::*;

	logic [3:0] field;
	logic [2:0] reg_idx;
	logic       hi_half;

	// ------------------------------------------------------------------------
	// Segment select
	// ------------------------------------------------------------------------
	always_comb begin
		seg.in_range  = 1'b0;
		seg.fixed_pci = 1'b0;
		reg_idx       = 3'd0;
		hi_half       = 1'b0;
		if (seg.addr[31:20] == 12'h000 && seg.addr[19:0] >= `LSAD_VIDEO_BASE) begin
			if (seg.addr[19:0] < `LSAD_EXP_BASE) begin
				seg.fixed_pci = 1'b1;
			end else if (seg.addr[19:0] >= `LSAD_BIOS_BASE) begin
				seg.in_range = 1'b1;
				reg_idx      = 3'd0;
				hi_half      = 1'b1;
			end else begin
				// 16 KB segments from C0000h: two per register starting at the second.
				seg.in_range = 1'b1;
				reg_idx      = 3'(seg.addr[17:15] + 3'd1);
				hi_half      = seg.addr[14];
			end
		end
		field = hi_half ? i_attr[reg_idx][7:4] : i_attr[reg_idx][3:0]; // R13
		seg.attr.read  = seg.in_range & field[`LSAD_FLD_READ];
		seg.attr.write = seg.in_range & field[`LSAD_FLD_WRITE];
		seg.attr.cache = seg.in_range & field[`LSAD_FLD_CACHE];
	end

endmodule

//--- design/lsad_top.sv
// Legacy 640 KB to 1 MB segment attribute decoder with APB register access.
`include "lsad_regs.svh"

// Operation
// R1: Seven byte attribute registers, reset zero, hold three bits for fourteen segments.
// R2: Read-route bit set sends processor reads to DRAM, else to PCI.
// R3: Write-route bit set sends processor writes to DRAM, else to PCI.
// R4: Cache-allow bit set marks processor accesses first-level cacheable.
// R5: Software never sets cache-allow while read-route is clear.
// R6: Cache-allow with write-route clear is cacheable only for code reads.
// R7: Read-only segment writes go to PCI; reads come from DRAM.
// R8: Read-only segments are never allocated or served by second-level cache.
// R9: Write-only segment reads skip DRAM and L2 and go to PCI.
// R10: Write-only segment writes are served by DRAM and L2; PCI master writes there are claimed with o_pci_l2_en off.
// R11: Read/write segment accesses from processor or PCI use DRAM and L2.
// R12: Disabled segment accesses are ignored by DRAM and cache, go to PCI.
// R13: Each register holds two 4-bit fields: read, write, cache, reserved.
// R14: PCI writes claimed only if writable, reads only if readable.
// R15: Attributes decoded every cycle; updates apply at the next access.
module lsad_top (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Processor access
	input  wire logic        i_cpu_valid,
	input  wire logic        i_cpu_write,
	input  wire logic        i_cpu_code,
	input  wire logic [31:0] i_cpu_addr,
	output lsad_pkg::lsad_dest_e o_cpu_dest,
	output logic             o_cpu_l2_en,
	output logic             o_cpu_l1_cacheable,
	// PCI master access
	input  wire logic        i_pci_valid,
	input  wire logic        i_pci_write,
	input  wire logic [31:0] i_pci_addr,
	output logic             o_pci_claim,
	output logic             o_pci_l2_en
);
	import lsad_pkg::*;

	// ------------------------------------------------------------------------
	// Attribute registers
	// ------------------------------------------------------------------------
	logic [7:0]  attr_q [`LSAD_NUM_REGS];
	logic [7:0]  attr_d [`LSAD_NUM_REGS];
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic [9:0]  reg_index;
	logic        hit;
	logic [2:0]  sel;
	logic        setup_phase;
	logic        access_phase;
	logic        wr_fire;
	logic [7:0]  wr_byte;
	logic [7:0]  rd_byte;
	logic [6:0]  wr_en;

	assign reg_index = i_paddr[11:2];

	// ------------------------------------------------------------------------
	// Register index decode
	// ------------------------------------------------------------------------
	// Each index is matched on its own, so an index between banks or a byte
	// address that is not word aligned can never alias one of the maps.
	always_comb begin
		hit = 1'b0;
		sel = 3'd0;
		if (i_paddr[1:0] == 2'b00) begin
			unique case (reg_index)
				{2'b00, `LSAD_IDX_ATTR_MAP_0}: begin
					hit = 1'b1;
					sel = 3'd0;
				end
				{2'b00, `LSAD_IDX_ATTR_MAP_1}: begin
					hit = 1'b1;
					sel = 3'd1;
				end
				{2'b00, `LSAD_IDX_ATTR_MAP_2}: begin
					hit = 1'b1;
					sel = 3'd2;
				end
				{2'b00, `LSAD_IDX_ATTR_MAP_3}: begin
					hit = 1'b1;
					sel = 3'd3;
				end
				{2'b00, `LSAD_IDX_ATTR_MAP_4}: begin
					hit = 1'b1;
					sel = 3'd4;
				end
				{2'b00, `LSAD_IDX_ATTR_MAP_5}: begin
					hit = 1'b1;
					sel = 3'd5;
				end
				{2'b00, `LSAD_IDX_ATTR_MAP_6}: begin
					hit = 1'b1;
					sel = 3'd6;
				end
				default: begin
					hit = 1'b0;
					sel = 3'd0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Register bus handshake
	// ------------------------------------------------------------------------
	// The slave answers in the first access cycle, so every transfer is two cycles.
	// A write lands only at the edge that completes its transfer; a master that
	// keeps penable up after the answer cannot store the same word twice.
	always_comb begin
		setup_phase  = i_psel && !i_penable;
		access_phase = i_psel && i_penable && pready_q;
		wr_fire      = access_phase && i_pwrite && hit && i_pstrb[0];
		wr_byte      = i_pwdata[7:0] & `LSAD_FIELD_MASK; // R13
	end

	// ------------------------------------------------------------------------
	// Write enables and read back
	// ------------------------------------------------------------------------
	// One write enable per map register, so no register is ever indexed out of range.
	always_comb begin
		for (int i = 0; i < `LSAD_NUM_REGS; i++) begin
			wr_en[i] = wr_fire && (sel == 3'(i));
		end
	end

	// Reserved bits are never stored, but the mask is applied again on read back.
	always_comb begin
		rd_byte = 8'h00;
		for (int i = 0; i < `LSAD_NUM_REGS; i++) begin
			if (sel == 3'(i)) begin
				rd_byte = attr_q[i] & `LSAD_FIELD_MASK;
			end
		end
	end

	// Read data and error are registered at the setup edge; the error stands for the one
	// access cycle, read data holds until the next setup, and a refused read returns zero.
	always_comb begin
		attr_d    = attr_q;
		prdata_d  = prdata_q;
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		if (setup_phase) begin
			pready_d  = 1'b1;
			pslverr_d = !hit;
			prdata_d  = 32'h0000_0000;
			if (hit && !i_pwrite) begin
				prdata_d = {24'h00_0000, rd_byte};
			end
		end
		for (int i = 0; i < `LSAD_NUM_REGS; i++) begin
			if (wr_en[i]) begin
				attr_d[i] = wr_byte; // R1 R13
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < `LSAD_NUM_REGS; i++) begin
				attr_q[i] <= `LSAD_ATTR_RESET; // R1
			end
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			attr_q    <= attr_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign o_prdata  = prdata_q;
	assign o_pready  = pready_q;
	assign o_pslverr = pslverr_q;

	// ------------------------------------------------------------------------
	// Lookups
	// ------------------------------------------------------------------------
	lsad_seg_if cpu_seg ();
	lsad_seg_if pci_seg ();

	assign cpu_seg.addr = i_cpu_addr;
	assign pci_seg.addr = i_pci_addr;

	// The lookup is purely combinational, so no flush follows a register write.
	lsad_seg_lookup u_cpu_lookup (
		.i_attr (attr_q),
		.seg    (cpu_seg)
	); // R15
	lsad_seg_lookup u_pci_lookup (
		.i_attr (attr_q),
		.seg    (pci_seg)
	);

	// ------------------------------------------------------------------------
	// Processor routing
	// ------------------------------------------------------------------------
	lsad_dest_e cpu_dest_q, cpu_dest_d;
	logic       cpu_l2_q, cpu_l2_d;
	logic       cpu_l1_q, cpu_l1_d;
	logic       to_dram;
	logic       cpu_read_only;
	logic       cpu_write_only;
	logic       cpu_read_write;
	logic       cpu_disabled;
	logic       cpu_code_read;

	// Read/write class of the addressed segment; the cache bit is kept apart from it.
	always_comb begin
		cpu_read_only  = cpu_seg.attr.read && !cpu_seg.attr.write;
		cpu_write_only = !cpu_seg.attr.read && cpu_seg.attr.write;
		cpu_read_write = cpu_seg.attr.read && cpu_seg.attr.write;
		cpu_disabled   = !cpu_seg.attr.read && !cpu_seg.attr.write;
		cpu_code_read  = i_cpu_code && !i_cpu_write;
	end

	// ------------------------------------------------------------------------
	// Processor destination
	// ------------------------------------------------------------------------
	always_comb begin
		cpu_dest_d = LSAD_DEST_NONE;
		cpu_l2_d   = 1'b0;
		cpu_l1_d   = 1'b0;
		to_dram    = 1'b0;
		if (i_cpu_valid) begin
			if (cpu_seg.fixed_pci) begin
				cpu_dest_d = LSAD_DEST_PCI;
			end else if (!cpu_seg.in_range) begin
				cpu_dest_d = LSAD_DEST_DRAM;
				cpu_l2_d   = 1'b1;
				cpu_l1_d   = 1'b1;
			end else begin
				to_dram = i_cpu_write ? cpu_seg.attr.write : cpu_seg.attr.read; // R2 R3
				if (cpu_disabled) begin
					to_dram = 1'b0; // R12
				end
				if (cpu_read_only) begin
					to_dram  = !i_cpu_write; // R7
					cpu_l2_d = 1'b0; // R8
				end
				if (cpu_write_only) begin
					to_dram  = i_cpu_write; // R9
					cpu_l2_d = i_cpu_write; // R10
				end
				if (cpu_read_write) begin
					to_dram  = 1'b1; // R11
					cpu_l2_d = 1'b1; // R11
				end
				cpu_dest_d = to_dram ? LSAD_DEST_DRAM : LSAD_DEST_PCI;
				// Code-only caching keeps a write-protected segment out of the data
				// cache, so a write that goes to PCI never leaves a stale line.
				if (cpu_seg.attr.cache) begin
					cpu_l1_d = cpu_seg.attr.write ? 1'b1 : cpu_code_read; // R4 R6
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cpu_dest_q <= LSAD_DEST_NONE;
			cpu_l2_q   <= 1'b0;
			cpu_l1_q   <= 1'b0;
		end else begin
			cpu_dest_q <= cpu_dest_d;
			cpu_l2_q   <= cpu_l2_d;
			cpu_l1_q   <= cpu_l1_d;
		end
	end

	assign o_cpu_dest         = cpu_dest_q;
	assign o_cpu_l2_en        = cpu_l2_q;
	assign o_cpu_l1_cacheable = cpu_l1_q;

	// ------------------------------------------------------------------------
	// PCI master claim
	// ------------------------------------------------------------------------
	logic pci_claim_q, pci_claim_d;
	logic pci_l2_q, pci_l2_d;
	logic pci_readable;
	logic pci_writable;
	logic pci_shared;

	// ------------------------------------------------------------------------
	// PCI master view of the segment
	// ------------------------------------------------------------------------
	// A master only sees a segment that the processor could reach the same way;
	// claiming anything else would hide the ROM that answers there.
	always_comb begin
		pci_readable = pci_seg.in_range && pci_seg.attr.read;
		pci_writable = pci_seg.in_range && pci_seg.attr.write;
		pci_shared   = pci_readable && pci_writable;
	end

	always_comb begin
		pci_claim_d = 1'b0;
		pci_l2_d    = 1'b0;
		if (i_pci_valid && !pci_seg.fixed_pci) begin
			if (pci_seg.in_range) begin
				pci_claim_d = i_pci_write ? pci_writable : pci_readable; // R14
				pci_l2_d    = pci_claim_d && pci_shared; // R11
			end else begin
				pci_claim_d = 1'b1;
				pci_l2_d    = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pci_claim_q <= 1'b0;
			pci_l2_q    <= 1'b0;
		end else begin
			pci_claim_q <= pci_claim_d;
			pci_l2_q    <= pci_l2_d;
		end
	end

	assign o_pci_claim = pci_claim_q;
	assign o_pci_l2_en = pci_l2_q;

endmodule

//--- tb/lsad_top_monitor.sv
// Port checker of the segment attribute decoder.
module lsad_top_monitor (
	// Clock, reset and register bus
	input wire logic                 i_clk,
	input wire logic                 i_reset_n,
	input wire logic                 i_psel,
	input wire logic                 i_penable,
	input wire logic [31:0]          o_prdata,
	input wire logic                 o_pready,
	input wire logic                 o_pslverr,
	// Accesses and their decode
	input wire logic                 i_cpu_valid,
	input wire logic [31:0]          i_cpu_addr,
	input wire lsad_pkg::lsad_dest_e o_cpu_dest,
	input wire logic                 o_cpu_l2_en,
	input wire logic                 o_cpu_l1_cacheable,
	input wire logic                 i_pci_valid,
	input wire logic [31:0]          i_pci_addr,
	input wire logic                 o_pci_claim,
	input wire logic                 o_pci_l2_en
);
	import lsad_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready) else $error("no ready");
	a_ready_one_cycle: assert property (o_pready |=> !o_pready) else $error("ready too long");
	a_error_with_ready: assert property (o_pslverr |-> o_pready) else $error("lone error");
	a_reserved_zero: assert property (o_pready && !o_pslverr |-> o_prdata[31:8] == 24'h000000 && !o_prdata[7]
		&& !o_prdata[3]) else $error("reserved bits set");
	a_decode_each_cycle: assert property (i_cpu_valid |=> o_cpu_dest != LSAD_DEST_NONE) else $error("no dest");
	a_idle_no_dest: assert property (!i_cpu_valid |=> o_cpu_dest == LSAD_DEST_NONE) else $error("idle dest");
	a_video_to_pci: assert property (i_cpu_valid && i_cpu_addr[31:17] == 15'h0005 |=> o_cpu_dest == LSAD_DEST_PCI
		&& !o_cpu_l1_cacheable && !o_cpu_l2_en) else $error("video decode");
	a_l2_needs_dram: assert property (o_cpu_l2_en |-> o_cpu_dest == LSAD_DEST_DRAM) else $error("l2 on pci");
	a_l1_needs_dram: assert property (o_cpu_l1_cacheable |-> o_cpu_dest == LSAD_DEST_DRAM) else $error("l1 on pci");
	a_pci_video_free: assert property (i_pci_valid && i_pci_addr[31:17] == 15'h0005 |=> !o_pci_claim)
		else $error("video claimed");
	a_pci_l2_claimed: assert property (o_pci_l2_en |-> o_pci_claim) else $error("pci l2 unclaimed");
	c_slave_error: cover property (o_pslverr);
	c_l1_cacheable: cover property (o_cpu_l1_cacheable);
	c_pci_l2: cover property (o_pci_claim && o_pci_l2_en);
endmodule
bind lsad_top lsad_top_monitor u_mon (.*);

//--- tb/lsad_host_model.sv
// Processor and PCI master stand-in issuing one access at a time.
module lsad_host_model (
	// Clock
	input  wire logic   i_clk,
	// Access request
	output logic        o_cpu_valid,
	output logic        o_cpu_write,
	output logic        o_cpu_code,
	output logic [31:0] o_cpu_addr,
	output logic        o_pci_valid,
	output logic        o_pci_write,
	output logic [31:0] o_pci_addr
);
	initial begin
		o_cpu_valid = 1'h0;
		o_cpu_write = 1'h0;
		o_cpu_code = 1'h0;
		o_cpu_addr = 32'h00000000;
		o_pci_valid = 1'h0;
		o_pci_write = 1'h0;
		o_pci_addr = 32'h00000000;
	end
	// Released address lines show the inverse so a stale value never decodes by luck.
	task automatic access(logic w, logic c, logic [31:0] a);
		@(posedge i_clk);
		o_cpu_valid <= 1'h1;
		o_cpu_write <= w;
		o_cpu_code <= c;
		o_cpu_addr <= a;
		o_pci_valid <= 1'h1;
		o_pci_write <= w;
		o_pci_addr <= a;
		@(posedge i_clk);
		o_cpu_valid <= 1'h0;
		o_pci_valid <= 1'h0;
		o_cpu_addr <= ~a;
		o_pci_addr <= ~a;
	endtask
endmodule

//--- tb/tb_legacy_segment_attribute_decode.sv
// Self-checking bench of the legacy segment attribute decoder.
`include "lsad_regs.svh"
module tb_legacy_segment_attribute_decode;
	timeunit 1ns;
	timeprecision 1ns;
	import lsad_pkg::*;
	typedef struct packed {logic [1:0] wc; logic [31:0] a; lsad_dest_e d; logic [3:0] f;} lsad_row_s;
	logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, r, ca, pa;
	logic [3:0]  pstrb = 4'hF;
	logic        pready, perr, e, cv, cw, cc, pv, pw, l2, l1, claim, pl2;
	lsad_dest_e  dest;
	int          errors = 0, n_compared = 0;
	// Flags are l2, l1, claim, pci l2; wc is write, code.
	lsad_row_s   rows [13] = '{
		'{2'h0, 32'h000C0000, LSAD_DEST_DRAM, 4'h2}, '{2'h2, 32'h000C0000, LSAD_DEST_PCI, 4'h0},
		'{2'h0, 32'h000C4000, LSAD_DEST_DRAM, 4'hB}, '{2'h2, 32'h000C7FFC, LSAD_DEST_DRAM, 4'hB},
		'{2'h0, 32'h000C8000, LSAD_DEST_PCI, 4'h0}, '{2'h2, 32'h000C8000, LSAD_DEST_DRAM, 4'hA},
		'{2'h1, 32'h000CC000, LSAD_DEST_DRAM, 4'h6}, '{2'h0, 32'h000CC000, LSAD_DEST_DRAM, 4'h2},
		'{2'h0, 32'h000D0000, LSAD_DEST_DRAM, 4'hF}, '{2'h0, 32'h000D4000, LSAD_DEST_PCI, 4'h0},
		'{2'h2, 32'h000D7FFC, LSAD_DEST_PCI, 4'h0}, '{2'h0, 32'h000A0000, LSAD_DEST_PCI, 4'h0},
		'{2'h0, 32'h000FFFFC, LSAD_DEST_DRAM, 4'hF}};
	lsad_top uut (.i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(perr), .i_cpu_valid(cv), .i_cpu_write(cw), .i_cpu_code(cc), .i_cpu_addr(ca),
		.o_cpu_dest(dest), .o_cpu_l2_en(l2), .o_cpu_l1_cacheable(l1), .i_pci_valid(pv),
		.i_pci_write(pw), .i_pci_addr(pa), .o_pci_claim(claim), .o_pci_l2_en(pl2));
	lsad_host_model u_host (.i_clk(clk), .o_cpu_valid(cv), .o_cpu_write(cw), .o_cpu_code(cc),
		.o_cpu_addr(ca), .o_pci_valid(pv), .o_pci_write(pw), .o_pci_addr(pa));
	initial forever #25 clk = ~clk;
	function automatic logic [11:0] ra(int i); return 12'((`LSAD_IDX_ATTR_MAP_0 + i) * 4); endfunction
	task automatic chk(string n, logic [31:0] x, logic [31:0] s);
		n_compared++;
		if (s !== x) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
		int n = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		pen <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1);
		chk("wait_states", 32'h0, 32'(n - 1));
		r = prdata;
		e = perr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask
	task automatic rd(int i, logic [31:0] x);
		apb(1'h0, ra(i), 32'h00000000, 4'hF);
		chk("attr_map", x, r);
	endtask
	task automatic acc(lsad_row_s w);
		u_host.access(w.wc[1], w.wc[0], w.a);
		@(negedge clk);
		chk("dest", 32'(w.d), 32'(dest));
		chk("flags", 32'(w.f), 32'({l2, l1, claim, pl2}));
	endtask
	task automatic end_of_test;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#100us;
		errors++;
		end_of_test;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		for (int i = 0; i < 7; i++) rd(i, 32'h00000000);
		apb(1'h1, ra(1), 32'h00000031, 4'hF);
		apb(1'h1, ra(2), 32'h00000052, 4'hF);
		apb(1'h1, ra(3), 32'h00000007, 4'hF);
		apb(1'h1, ra(0), 32'h000000F0, 4'hF);
		foreach (rows[i]) acc(rows[i]);
		rd(0, 32'h00000070);
		apb(1'h1, ra(6), 32'h000000FF, 4'hF);
		rd(6, 32'h00000077);
		apb(1'h1, ra(6), 32'h00000000, 4'hE);
		rd(6, 32'h00000077);
		apb(1'h0, 12'h000, 32'h00000000, 4'hF);
		chk("pslverr", 32'h1, 32'(e));
		apb(1'h1, ra(1), 32'h00000000, 4'hF);
		acc('{2'h0, 32'h000C0000, LSAD_DEST_PCI, 4'h0});
		@(posedge clk);
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		rd(3, 32'h00000000);
		end_of_test;
	end
endmodule
